// *** hw/pem_pkg.sv ***
package pem_pkg;
  localparam int unsigned pem_ctr_w = 32;
  localparam int unsigned pem_sel_w = 8;
  localparam int unsigned pem_ev_w = 12;
  localparam logic [7:0] pem_src_none = 8'h00;
  localparam logic [7:0] pem_src_inv_dword = 8'h01;
  localparam logic [7:0] pem_src_disparity = 8'h02;
  localparam logic [7:0] pem_src_sync_loss = 8'h03;
  localparam logic [7:0] pem_src_reset_prob = 8'h04;
  localparam logic [7:0] pem_src_elastic = 8'h05;
  localparam logic [7:0] pem_src_rx_error = 8'h06;
  localparam logic [7:0] pem_src_phy_rsvd_lo = 8'h07;
  localparam logic [7:0] pem_src_phy_rsvd_hi = 8'h1f;
  localparam logic [7:0] pem_src_addr_frame = 8'h20;
  localparam logic [7:0] pem_src_tx_abandon = 8'h21;
  localparam logic [7:0] pem_src_rx_abandon = 8'h22;
  localparam logic [7:0] pem_src_tx_retry = 8'h23;
  localparam logic [7:0] pem_src_rx_retry = 8'h24;
  localparam logic [7:0] pem_sel_reset = 8'h00;
  localparam logic [31:0] pem_ctr_reset = 32'h0000_0000;
  localparam int unsigned pem_num_sat = 4;
  // Event vector bit positions.
  localparam int unsigned pem_ev_inv_dword = 0;
  localparam int unsigned pem_ev_disparity = 1;
  localparam int unsigned pem_ev_sync_loss = 2;
  localparam int unsigned pem_ev_reset_prob = 3;
  localparam int unsigned pem_ev_elastic = 4;
  localparam int unsigned pem_ev_rx_error = 5;
  localparam int unsigned pem_ev_addr_frame = 6;
  localparam int unsigned pem_ev_tx_abandon = 7;
  localparam int unsigned pem_ev_rx_abandon = 8;
  localparam int unsigned pem_ev_tx_retry = 9;
  localparam int unsigned pem_ev_rx_retry = 10;
  localparam int unsigned pem_ev_spare = 11;
endpackage : pem_pkg

// *** hw/pem_event_qual.sv ***
`timescale 1ns/1ps
`default_nettype none
module pem_event_qual (
  input wire logic mclk,
  input wire logic reset,
  input wire logic in_phy_reset,
  input wire logic invalid_dword,
  input wire logic disparity_error,
  input wire logic sync_loss_restart,
  input wire logic reset_problem,
  input wire logic elastic_overflow,
  input wire logic rx_error_prim,
  input wire logic addr_frame_bad,
  input wire logic tx_abandon_reject,
  input wire logic tx_reject_forwarded,
  input wire logic rx_abandon_reject,
  input wire logic rx_retry_reject,
  input wire logic open_forwarded,
  input wire logic tx_retry_reject,
  output logic [pem_pkg::pem_ev_w-1:0] events
);
  typedef struct packed {
    logic [pem_pkg::pem_ev_w-1:0] ev;
  } pem_qual_t;
  pem_qual_t st, next_st;

  always_comb begin
    next_st = st;
    next_st.ev = '0;
    next_st.ev[pem_pkg::pem_ev_inv_dword] = invalid_dword && !in_phy_reset;
    next_st.ev[pem_pkg::pem_ev_disparity] = disparity_error && !in_phy_reset;
    next_st.ev[pem_pkg::pem_ev_sync_loss] = sync_loss_restart;
    next_st.ev[pem_pkg::pem_ev_reset_prob] = reset_problem;
    next_st.ev[pem_pkg::pem_ev_elastic] = elastic_overflow && !in_phy_reset;
    next_st.ev[pem_pkg::pem_ev_rx_error] = rx_error_prim;
    next_st.ev[pem_pkg::pem_ev_addr_frame] = addr_frame_bad;
    next_st.ev[pem_pkg::pem_ev_tx_abandon] = tx_abandon_reject && !tx_reject_forwarded;
    next_st.ev[pem_pkg::pem_ev_rx_abandon] = rx_abandon_reject && !open_forwarded;
    next_st.ev[pem_pkg::pem_ev_tx_retry] = tx_retry_reject && !tx_reject_forwarded;
    next_st.ev[pem_pkg::pem_ev_rx_retry] = rx_retry_reject && !open_forwarded;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign events = st.ev;

  a_reset_gate: assert property (@(posedge mclk) disable iff (reset)
    in_phy_reset |=> !events[pem_pkg::pem_ev_inv_dword] && !events[pem_pkg::pem_ev_elastic])
    else $error("event counted during phy reset");
  a_fwd_excl: assert property (@(posedge mclk) disable iff (reset)
    open_forwarded |=> !events[pem_pkg::pem_ev_rx_abandon] && !events[pem_pkg::pem_ev_rx_retry])
    else $error("forwarded open answer counted");
  a_disp_pass: assert property (@(posedge mclk) disable iff (reset)
    disparity_error && !in_phy_reset |=> events[pem_pkg::pem_ev_disparity])
    else $error("disparity event lost");
endmodule : pem_event_qual
`default_nettype wire

// *** hw/pem_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
module pem_counter #(
  parameter int unsigned WIDTH = 32,
  parameter bit SATURATE = 1'b0
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clear,
  input wire logic inc,
  output logic [WIDTH-1:0] count
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } pem_cnt_t;
  pem_cnt_t st, next_st;

  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.cnt = '0;
    end else if (inc) begin
      if (SATURATE && (&st.cnt)) begin
        next_st.cnt = st.cnt;
      end else begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st.cnt <= WIDTH'(pem_pkg::pem_ctr_reset);
    end else begin
      st <= next_st;
    end
  end

  assign count = st.cnt;

  a_sat_hold: assert property (@(posedge mclk) disable iff (reset)
    SATURATE && (&count) && !clear |=> (&count))
    else $error("saturating counter rolled over");
  a_wrap_zero: assert property (@(posedge mclk) disable iff (reset)
    !SATURATE && (&count) && inc && !clear |=> count == '0)
    else $error("wrapping counter did not roll to zero");
  a_inc_step: assert property (@(posedge mclk) disable iff (reset)
    inc && !clear && !(&count) |=> count == $past(count) + 1'b1)
    else $error("counter did not step by one");
endmodule : pem_counter
`default_nettype wire

// *** hw/pem_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module pem_monitor #(
  parameter int unsigned NUM_SLOTS = 2,
  parameter int unsigned CTR_W = pem_pkg::pem_ctr_w
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic in_phy_reset,
  input wire logic invalid_dword,
  input wire logic disparity_error,
  input wire logic sync_loss_restart,
  input wire logic reset_problem,
  input wire logic elastic_overflow,
  input wire logic rx_error_prim,
  input wire logic addr_frame_bad,
  input wire logic tx_abandon_reject,
  input wire logic tx_retry_reject,
  input wire logic tx_reject_forwarded,
  input wire logic rx_abandon_reject,
  input wire logic rx_retry_reject,
  input wire logic open_forwarded,
  input wire logic sel_write,
  input wire logic [$clog2(NUM_SLOTS > 1 ? NUM_SLOTS : 2)-1:0] sel_slot,
  input wire logic [pem_pkg::pem_sel_w-1:0] sel_code,
  output logic [NUM_SLOTS*pem_pkg::pem_sel_w-1:0] slot_selector,
  output logic [NUM_SLOTS*CTR_W-1:0] slot_count,
  output logic [pem_pkg::pem_num_sat*CTR_W-1:0] sat_count
);
  localparam int unsigned SLOT_W = $clog2(NUM_SLOTS > 1 ? NUM_SLOTS : 2);

  typedef struct packed {
    logic [NUM_SLOTS-1:0][pem_pkg::pem_sel_w-1:0] sel;
  } pem_mon_t;
  pem_mon_t st, next_st;

  logic [pem_pkg::pem_ev_w-1:0] events;
  logic [NUM_SLOTS-1:0] slot_inc;
  logic [NUM_SLOTS-1:0] slot_clear;

  // Maps a selector code to its qualified event; unassigned codes give no event.
  function automatic logic pem_pick(input logic [pem_pkg::pem_sel_w-1:0] code,
                                    input logic [pem_pkg::pem_ev_w-1:0] ev);
    logic hit;
    hit = 1'b0;
    unique case (code)
      pem_pkg::pem_src_inv_dword: hit = ev[pem_pkg::pem_ev_inv_dword];
      pem_pkg::pem_src_disparity: hit = ev[pem_pkg::pem_ev_disparity];
      pem_pkg::pem_src_sync_loss: hit = ev[pem_pkg::pem_ev_sync_loss];
      pem_pkg::pem_src_reset_prob: hit = ev[pem_pkg::pem_ev_reset_prob];
      pem_pkg::pem_src_elastic: hit = ev[pem_pkg::pem_ev_elastic];
      pem_pkg::pem_src_rx_error: hit = ev[pem_pkg::pem_ev_rx_error];
      pem_pkg::pem_src_addr_frame: hit = ev[pem_pkg::pem_ev_addr_frame];
      pem_pkg::pem_src_tx_abandon: hit = ev[pem_pkg::pem_ev_tx_abandon];
      pem_pkg::pem_src_rx_abandon: hit = ev[pem_pkg::pem_ev_rx_abandon];
      pem_pkg::pem_src_tx_retry: hit = ev[pem_pkg::pem_ev_tx_retry];
      pem_pkg::pem_src_rx_retry: hit = ev[pem_pkg::pem_ev_rx_retry];
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : pem_pick

  pem_event_qual u_qual (
    .mclk(mclk),
    .reset(reset),
    .in_phy_reset(in_phy_reset),
    .invalid_dword(invalid_dword),
    .disparity_error(disparity_error),
    .sync_loss_restart(sync_loss_restart),
    .reset_problem(reset_problem),
    .elastic_overflow(elastic_overflow),
    .rx_error_prim(rx_error_prim),
    .addr_frame_bad(addr_frame_bad),
    .tx_abandon_reject(tx_abandon_reject),
    .tx_reject_forwarded(tx_reject_forwarded),
    .rx_abandon_reject(rx_abandon_reject),
    .rx_retry_reject(rx_retry_reject),
    .open_forwarded(open_forwarded),
    .tx_retry_reject(tx_retry_reject),
    .events(events)
  );

  always_comb begin
    next_st = st;
    slot_inc = '0;
    slot_clear = '0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      slot_inc[i] = pem_pick(st.sel[i], events);
      if (sel_write && (sel_slot == SLOT_W'(i))) begin
        next_st.sel[i] = sel_code;
        slot_clear[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        st.sel[i] <= pem_pkg::pem_sel_reset;
      end
    end else begin
      st <= next_st;
    end
  end

  assign slot_selector = st.sel;

  for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
    pem_counter #(
      .WIDTH(CTR_W),
      .SATURATE(1'b0)
    ) u_wrap (
      .mclk(mclk),
      .reset(reset),
      .clear(slot_clear[g]),
      .inc(slot_inc[g]),
      .count(slot_count[g*CTR_W +: CTR_W])
    );
  end

  // Fixed saturating counters run alongside the slots, one per event 01h to 04h.
  for (genvar s = 0; s < pem_pkg::pem_num_sat; s++) begin : g_sat
    pem_counter #(
      .WIDTH(CTR_W),
      .SATURATE(1'b1)
    ) u_sat (
      .mclk(mclk),
      .reset(reset),
      .clear(1'b0),
      .inc(events[s]),
      .count(sat_count[s*CTR_W +: CTR_W])
    );
  end

  sequence s_sel_write0;
    sel_write && sel_slot == '0;
  endsequence

  a_none_idle: assert property (@(posedge mclk) disable iff (reset)
    st.sel[0] == pem_pkg::pem_src_none |-> !slot_inc[0])
    else $error("no-event selector counted");
  a_rsvd_idle: assert property (@(posedge mclk) disable iff (reset)
    st.sel[0] >= pem_pkg::pem_src_phy_rsvd_lo && st.sel[0] <= pem_pkg::pem_src_phy_rsvd_hi
    |-> !slot_inc[0])
    else $error("reserved selector counted");
  a_sel_clear: assert property (@(posedge mclk) disable iff (reset)
    s_sel_write0 |=> slot_count[CTR_W-1:0] == '0 && st.sel[0] == $past(sel_code))
    else $error("selector write did not clear slot");
  a_err_count: assert property (@(posedge mclk) disable iff (reset)
    st.sel[0] == pem_pkg::pem_src_rx_error && events[pem_pkg::pem_ev_rx_error] && !sel_write
    |=> slot_count[CTR_W-1:0] == $past(slot_count[CTR_W-1:0]) + 1'b1)
    else $error("error primitive not counted");
  a_sat_track: assert property (@(posedge mclk) disable iff (reset)
    events[pem_pkg::pem_ev_reset_prob] && !(&sat_count[4*CTR_W-1:3*CTR_W])
    |=> sat_count[4*CTR_W-1:3*CTR_W] != $past(sat_count[4*CTR_W-1:3*CTR_W]))
    else $error("saturating reset problem count missed");

  // Slot 0 per code: a qualified event steps the count once and a quiet cycle leaves it
  // alone; a write of the slot 0 selector in the same cycle takes precedence over both.
  sequence s_slot0_hit(logic [pem_pkg::pem_sel_w-1:0] code, logic ev);
    st.sel[0] == code && ev && !sel_write;
  endsequence

  sequence s_slot0_quiet(logic [pem_pkg::pem_sel_w-1:0] code, logic ev);
    st.sel[0] == code && !ev && !sel_write;
  endsequence

  property p_slot0_step(logic [pem_pkg::pem_sel_w-1:0] code, logic ev);
    @(posedge mclk) disable iff (reset)
    s_slot0_hit(code, ev) |=> slot_count[CTR_W-1:0] == $past(slot_count[CTR_W-1:0]) + 1'b1;
  endproperty

  property p_slot0_hold(logic [pem_pkg::pem_sel_w-1:0] code, logic ev);
    @(posedge mclk) disable iff (reset)
    s_slot0_quiet(code, ev) |=> $stable(slot_count[CTR_W-1:0]);
  endproperty

  a_inv_step: assert property (p_slot0_step(pem_pkg::pem_src_inv_dword,
    events[pem_pkg::pem_ev_inv_dword]))
    else $error("invalid dword not counted");
  a_disp_step: assert property (p_slot0_step(pem_pkg::pem_src_disparity,
    events[pem_pkg::pem_ev_disparity]))
    else $error("disparity error not counted");
  a_sync_step: assert property (p_slot0_step(pem_pkg::pem_src_sync_loss,
    events[pem_pkg::pem_ev_sync_loss]))
    else $error("sync loss restart not counted");
  a_rprob_step: assert property (p_slot0_step(pem_pkg::pem_src_reset_prob,
    events[pem_pkg::pem_ev_reset_prob]))
    else $error("phy reset problem not counted");
  a_elast_step: assert property (p_slot0_step(pem_pkg::pem_src_elastic,
    events[pem_pkg::pem_ev_elastic]))
    else $error("elasticity overflow not counted");
  a_frame_step: assert property (p_slot0_step(pem_pkg::pem_src_addr_frame,
    events[pem_pkg::pem_ev_addr_frame]))
    else $error("bad address frame not counted");
  a_txab_step: assert property (p_slot0_step(pem_pkg::pem_src_tx_abandon,
    events[pem_pkg::pem_ev_tx_abandon]))
    else $error("sent abandon reject not counted");
  a_rxab_step: assert property (p_slot0_step(pem_pkg::pem_src_rx_abandon,
    events[pem_pkg::pem_ev_rx_abandon]))
    else $error("received abandon reject not counted");
  a_txrt_step: assert property (p_slot0_step(pem_pkg::pem_src_tx_retry,
    events[pem_pkg::pem_ev_tx_retry]))
    else $error("sent retry reject not counted");
  a_rxrt_step: assert property (p_slot0_step(pem_pkg::pem_src_rx_retry,
    events[pem_pkg::pem_ev_rx_retry]))
    else $error("received retry reject not counted");

  // A selected event that did not occur must leave the slot count where it was.
  a_inv_hold: assert property (p_slot0_hold(pem_pkg::pem_src_inv_dword,
    events[pem_pkg::pem_ev_inv_dword]))
    else $error("invalid dword count moved without event");
  a_disp_hold: assert property (p_slot0_hold(pem_pkg::pem_src_disparity,
    events[pem_pkg::pem_ev_disparity]))
    else $error("disparity count moved without event");
  a_sync_hold: assert property (p_slot0_hold(pem_pkg::pem_src_sync_loss,
    events[pem_pkg::pem_ev_sync_loss]))
    else $error("sync loss count moved without event");
  a_rprob_hold: assert property (p_slot0_hold(pem_pkg::pem_src_reset_prob,
    events[pem_pkg::pem_ev_reset_prob]))
    else $error("reset problem count moved without event");
  a_elast_hold: assert property (p_slot0_hold(pem_pkg::pem_src_elastic,
    events[pem_pkg::pem_ev_elastic]))
    else $error("overflow count moved without event");
  a_err_hold: assert property (p_slot0_hold(pem_pkg::pem_src_rx_error,
    events[pem_pkg::pem_ev_rx_error]))
    else $error("error primitive count moved without event");
  a_frame_hold: assert property (p_slot0_hold(pem_pkg::pem_src_addr_frame,
    events[pem_pkg::pem_ev_addr_frame]))
    else $error("address frame count moved without event");
  a_txab_hold: assert property (p_slot0_hold(pem_pkg::pem_src_tx_abandon,
    events[pem_pkg::pem_ev_tx_abandon]))
    else $error("sent abandon count moved without event");
  a_rxab_hold: assert property (p_slot0_hold(pem_pkg::pem_src_rx_abandon,
    events[pem_pkg::pem_ev_rx_abandon]))
    else $error("received abandon count moved without event");
  a_txrt_hold: assert property (p_slot0_hold(pem_pkg::pem_src_tx_retry,
    events[pem_pkg::pem_ev_tx_retry]))
    else $error("sent retry count moved without event");
  a_rxrt_hold: assert property (p_slot0_hold(pem_pkg::pem_src_rx_retry,
    events[pem_pkg::pem_ev_rx_retry]))
    else $error("received retry count moved without event");

  // Each saturating counter steps with its event until it is full.
  property p_sat_step(int idx);
    @(posedge mclk) disable iff (reset)
    events[idx] && !(&sat_count[idx*CTR_W +: CTR_W])
    |=> sat_count[idx*CTR_W +: CTR_W] == $past(sat_count[idx*CTR_W +: CTR_W]) + 1'b1;
  endproperty

  a_sat_inv: assert property (p_sat_step(pem_pkg::pem_ev_inv_dword))
    else $error("saturating invalid dword count missed");
  a_sat_disp: assert property (p_sat_step(pem_pkg::pem_ev_disparity))
    else $error("saturating disparity count missed");
  a_sat_sync: assert property (p_sat_step(pem_pkg::pem_ev_sync_loss))
    else $error("saturating sync loss count missed");
  a_sat_rprob: assert property (p_sat_step(pem_pkg::pem_ev_reset_prob))
    else $error("saturating reset problem step missed");

  for (genvar h = 0; h < pem_pkg::pem_num_sat; h++) begin : g_sat_chk
    a_sat_keep: assert property (@(posedge mclk) disable iff (reset)
      !events[h] |=> $stable(sat_count[h*CTR_W +: CTR_W]))
      else $error("saturating count moved without its event");
  end

  // The selector holds without a write; gating seen from the slot: a gated event one cycle earlier must not reach the count.
  a_sel_hold: assert property (@(posedge mclk) disable iff (reset)
    !sel_write |=> $stable(slot_selector))
    else $error("selector changed without a write");
  a_slot_gate: assert property (@(posedge mclk) disable iff (reset)
    st.sel[0] == pem_pkg::pem_src_inv_dword && $past(in_phy_reset) && !sel_write
    |=> $stable(slot_count[CTR_W-1:0]))
    else $error("invalid dword counted inside phy reset");
  a_slot_fwd: assert property (@(posedge mclk) disable iff (reset)
    st.sel[0] == pem_pkg::pem_src_rx_retry && $past(open_forwarded) && !sel_write
    |=> $stable(slot_count[CTR_W-1:0]))
    else $error("answer to forwarded open counted");
  a_fwd_reject: assert property (@(posedge mclk) disable iff (reset)
    st.sel[0] == pem_pkg::pem_src_tx_abandon && $past(tx_reject_forwarded) && !sel_write
    |=> $stable(slot_count[CTR_W-1:0]))
    else $error("forwarded abandon reject counted");

  // Every slot, not only slot 0, is cleared by a write of its selector.
  for (genvar c = 0; c < NUM_SLOTS; c++) begin : g_slot_chk
    a_slot_clear: assert property (@(posedge mclk) disable iff (reset)
      sel_write && sel_slot == SLOT_W'(c) |=> slot_count[c*CTR_W +: CTR_W] == '0)
      else $error("selector write did not clear its slot");
  end
endmodule : pem_monitor
`default_nettype wire

// *** dv/pem_phy_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Attached phy: turns one stimulus word into event pulses and qualifiers for one cycle.
module pem_phy_model (
  input wire logic [31:0] word,
  output logic [10:0] events,
  output logic tx_fwd,
  output logic open_fwd,
  output logic in_reset
);
  assign events = word[10:0];
  assign tx_fwd = word[11] & word[16];
  assign open_fwd = word[12] & word[17];
  assign in_reset = word[14] & word[15];
endmodule : pem_phy_model
`default_nettype wire

// *** dv/pem_monitor_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module pem_monitor_tb_top;
  localparam int unsigned cw = 4;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic armed = 1'b0;
  logic [31:0] word = 32'h0;
  logic [31:0] lfsr = 32'h81bc;
  logic sel_write = 1'b0;
  logic sel_slot = 1'b0;
  logic [7:0] sel_code = 8'h00;
  wire logic [10:0] ev;
  wire logic txf, opf, inr;
  logic [15:0] slot_selector;
  logic [2*cw-1:0] slot_count;
  logic [4*cw-1:0] sat_count;
  logic [10:0] stage;
  logic [cw-1:0] m_cnt [2];
  logic [7:0] m_sel [2];
  logic [cw-1:0] m_sat [4];
  int n_mismatch = 0;
  int samples_checked = 0;
  always #20 mclk = ~mclk;
  pem_phy_model i_pem_phy_model (.word(word), .events(ev), .tx_fwd(txf), .open_fwd(opf),
    .in_reset(inr));
  pem_monitor #(.NUM_SLOTS(2), .CTR_W(cw)) i_pem_monitor (.mclk(mclk), .reset(reset),
    .in_phy_reset(inr), .invalid_dword(ev[0]), .disparity_error(ev[1]),
    .sync_loss_restart(ev[2]), .reset_problem(ev[3]), .elastic_overflow(ev[4]),
    .rx_error_prim(ev[5]), .addr_frame_bad(ev[6]), .tx_abandon_reject(ev[7]),
    .rx_abandon_reject(ev[8]), .tx_retry_reject(ev[9]), .rx_retry_reject(ev[10]),
    .tx_reject_forwarded(txf), .open_forwarded(opf), .sel_write(sel_write),
    .sel_slot(sel_slot), .sel_code(sel_code), .slot_selector(slot_selector),
    .slot_count(slot_count), .sat_count(sat_count));
  function automatic logic [31:0] next_rand();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c1_1db7 : 32'h0);
    return lfsr;
  endfunction : next_rand
  function automatic int evbit(logic [7:0] c);
    if (c >= 8'h01 && c <= 8'h06) return int'(c) - 1;
    if (c >= 8'h20 && c <= 8'h24) return int'(c) - 26;
    return -1;
  endfunction : evbit
  function automatic logic [10:0] qualify(logic [10:0] e, logic r, logic tf, logic of);
    logic [10:0] q;
    q = e;
    if (r) begin
      q[0] = 1'b0;
      q[1] = 1'b0;
      q[4] = 1'b0;
    end
    if (tf) begin
      q[7] = 1'b0;
      q[9] = 1'b0;
    end
    if (of) begin
      q[8] = 1'b0;
      q[10] = 1'b0;
    end
    return q;
  endfunction : qualify
  // Reference: one qualify stage, then the counters; a selector write clears its slot.
  always @(posedge mclk) begin
    int b;
    if (reset) begin
      stage = '0;
      m_cnt = '{default: '0};
      m_sel = '{default: 8'h00};
      m_sat = '{default: '0};
    end else begin
      for (int i = 0; i < 2; i++) begin
        b = evbit(m_sel[i]);
        if (b >= 0 && stage[b]) m_cnt[i] = m_cnt[i] + 1'b1;
      end
      for (int i = 0; i < 4; i++) begin
        if (stage[i] && m_sat[i] != {cw{1'b1}}) m_sat[i] = m_sat[i] + 1'b1;
      end
      stage = qualify(ev, inr, txf, opf);
      if (sel_write) begin
        m_sel[sel_slot] = sel_code;
        m_cnt[sel_slot] = '0;
      end
    end
  end
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (exp !== got) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  always @(negedge mclk) begin
    if (armed) begin
      check("slot_selector", {16'h0, m_sel[1], m_sel[0]}, {16'h0, slot_selector});
      check("slot_count", {24'h0, m_cnt[1], m_cnt[0]}, {24'h0, slot_count});
      check("sat_count", {16'h0, m_sat[3], m_sat[2], m_sat[1], m_sat[0]}, {16'h0, sat_count});
    end
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic cyc(int n, bit rnd, logic [31:0] w);
    repeat (n) begin
      @(posedge mclk);
      #1 word = rnd ? next_rand() : w;
    end
  endtask : cyc
  // Events are held quiet around a selector write so none sits in the qualify stage.
  task automatic write_sel(logic s, logic [7:0] c);
    cyc(2, 1'b0, 32'h0);
    @(posedge mclk);
    #1 sel_write = 1'b1;
    sel_slot = s;
    sel_code = c;
    @(posedge mclk);
    #1 sel_write = 1'b0;
  endtask : write_sel
  logic [7:0] codes [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'hff};
  initial begin
    @(posedge mclk);
    #1 armed = 1'b1;
    repeat (19) @(posedge mclk);
    #1 reset = 1'b0;
    for (int k = 0; k < 32; k++) begin
      write_sel(k[0], codes[k[4:1]]);
      cyc(40, 1'b1, 32'h0);
    end
    write_sel(1'b0, 8'h01);
    write_sel(1'b1, 8'h22);
    cyc(20, 1'b0, 32'h0000_07ff);
    cyc(20, 1'b0, 32'h0003_ffff);
    @(posedge mclk);
    #1 reset = 1'b1;
    cyc(2, 1'b0, 32'h0);
    reset = 1'b0;
    write_sel(1'b1, 8'h20);
    cyc(100, 1'b1, 32'h0);
    cyc(3, 1'b0, 32'h0);
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    complete_run();
  end
endmodule : pem_monitor_tb_top
`default_nettype wire
